// File: dnc_pkg.sv
// Purpose: Shared constants and types for the down-converter configuration bank
// Assumes: Byte-wide register access through the serial programming port
// Notes:   Offsets are byte addresses on the programming port
package dnc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [11:0] ADDR_COMPLEX_CFG  = 12'h162;
  localparam logic [11:0] ADDR_SOURCE_SEL   = 12'h163;
  localparam logic [11:0] ADDR_OSC_UPD_MODE = 12'h164;
  localparam logic [11:0] ADDR_OSC_SEL_CTRL = 12'h165;
  localparam logic [11:0] ADDR_FREQ_SEL     = 12'h166;
  localparam logic [11:0] ADDR_DECIM_LOW    = 12'h167;
  localparam logic [11:0] ADDR_DECIM_HIGH   = 12'h168;
  localparam logic [11:0] ADDR_DECIM_COMMON = 12'h169;
  localparam logic [11:0] ADDR_ZONE_CFG     = 12'h16b;
  localparam logic [11:0] ADDR_FREQ_BASE    = 12'h200;
  localparam logic [11:0] ADDR_FREQ_LAST    = 12'h27f;

  localparam logic [7:0]  RESET_BYTE        = 8'h00;
  localparam logic [2:0]  RESET_ZONE        = 3'h0;

  // ==========================================================================
  // Field positions
  localparam int BIT_COMPLEX_EN   = 2;
  localparam int BIT_OSC_UPD_LO   = 4;
  localparam int BIT_NEG_IMAGE    = 3;
  localparam int BIT_OSC_MODE     = 0;
  localparam int BIT_LOW_LATENCY  = 4;
  localparam int BIT_AUTOLOAD_DIS = 2;
  localparam int BIT_FSEL_SRC     = 1;
  localparam int BIT_COMMON_UPD   = 0;
  localparam int BIT_UNEQUAL      = 7;
  localparam int BIT_ZONE_UPD     = 4;
  localparam int NUM_CONV         = 4;
  localparam int NUM_WORDS        = 4;
  localparam int FREQ_BYTES       = 6;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] SRC_CODE_00 = 2'h0;
  localparam logic [1:0] SRC_CODE_01 = 2'h1;
  localparam logic [3:0] DECIM_BYPASS = 4'h0;
  localparam logic [3:0] DECIM_MAX    = 4'hf;

  typedef enum logic [1:0] {
    DNC_MODE_DUAL   = 2'h0,
    DNC_MODE_QUAD   = 2'h1,
    DNC_MODE_SINGLE = 2'h2,
    DNC_MODE_UNUSED = 2'h3
  } dnc_count_t;

  // Byte access on the programming port
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } dnc_access_t;

  // Per-converter settings handed to the datapath
  typedef struct packed {
    logic        connected;
    logic [3:0]  decim_code;
    logic [15:0] decim_factor;
    logic        bypass;
    logic [1:0]  freq_index;
    logic [47:0] active_freq;
  } dnc_conv_t;

  // Global settings handed to the datapath
  typedef struct packed {
    logic        complex_en;
    logic        neg_image;
    logic        coherent;
    logic        low_latency;
    dnc_count_t  count;
    logic [2:0]  zone;
  } dnc_global_t;

endpackage : dnc_pkg

// File: dnc_rise_detect.sv
// Purpose: Rising-edge detector on a register bit
// Assumes: Input is a register output in the same clock domain
// Notes:   Pulse lasts one cycle
`timescale 1ns/1ps
module dnc_rise_detect (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic level,
  output      logic pulse
);

  logic prev_reg;

  // ==========================================================================
  // Delayed copy for edge compare
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level;
    end
  end

  assign pulse = level & ~prev_reg;

endmodule : dnc_rise_detect

// File: dnc_osc_slot.sv
// Purpose: Frequency word store and load for one oscillator
// Assumes: Words are written byte by byte, little endian
// Notes:   Loaded copy changes only on a load pulse
`timescale 1ns/1ps
module dnc_osc_slot (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        byte_we,
  input  wire logic [4:0]  byte_index,
  input  wire logic [7:0]  byte_data,
  input  wire logic        load,
  input  wire logic [1:0]  select,
  output      logic [47:0] active_freq,
  output      logic [7:0]  byte_rdata
);

  localparam int NBYTES = dnc_pkg::NUM_WORDS * dnc_pkg::FREQ_BYTES;

  logic [7:0]  prog_mem [0:NBYTES-1];
  logic [47:0] live_reg [0:dnc_pkg::NUM_WORDS-1];

  // Raw byte read-back for the programming port
  assign byte_rdata = prog_mem[byte_index];

  // ==========================================================================
  // Programmed bytes and loaded words
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NBYTES; i++) prog_mem[i] <= dnc_pkg::RESET_BYTE;
      for (int w = 0; w < dnc_pkg::NUM_WORDS; w++) live_reg[w] <= 48'h0;
    end else begin
      if (byte_we) prog_mem[byte_index] <= byte_data;
      if (load) begin
        for (int w = 0; w < dnc_pkg::NUM_WORDS; w++) begin
          for (int b = 0; b < dnc_pkg::FREQ_BYTES; b++) begin
            live_reg[w][8*b+:8] <= prog_mem[w*dnc_pkg::FREQ_BYTES+b];
          end
        end
      end
    end
  end

  // Active word is the loaded copy, not the raw bytes
  assign active_freq = live_reg[select];

endmodule : dnc_osc_slot

// File: dnc_config_regs.sv
// Purpose: Down-converter and oscillator configuration register bank
// Assumes: Byte register port, inputs synchronous to clock
// Notes:   Update bits are level registers; updates fire on written rising edges
`timescale 1ns/1ps

// How it works
// - Converters 1 and 3: code 00 unconnected, 01 channel A.
// - Converters 0 and 2: code 00 channel A, 01 unconnected.
// - Rising edge on bits 7..4 loads that oscillator's four words.
// - Bit 3 picks negative image, only with complex decimation on.
// - Mode bit: 0 phase continuous, 1 infinitely phase coherent.
// - Bit 4 set bypasses all digital processing.
// - Bit 2 set stops automatic load on pin-driven selection change.
// - Select source: 0 from pins, 1 from select register.
// - Rising edge on common bit 0 loads all oscillators.
// - Per-converter 2-bit field picks one of four words.
// - Per-converter decimation applies only with unequal decimation.
// - Code 0000 bypass, 0001 by 2, 0010 by 4, up to 32768.
// - Unequal bit 7: 0 common factor, 1 per-converter factors.
// - Count field 00 dual, 01 quad, 10 single; resets to 00.
// - Common decimation field bits 3-0 sets all active converters.
// - Complex enable bit: 0 real, 1 complex decimation.
// - Zone copied internally only on rising edge of zone update bit.
// - Each oscillator holds four 48-bit little-endian words.
module dnc_config_regs (
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire dnc_pkg::dnc_access_t access,
  output      logic [7:0]           rdata,
  input  wire logic [7:0]           pin_freq_select,
  input  wire logic [15:0]          channel_a,
  output      logic [15:0]          conv_data [0:3],
  output      dnc_pkg::dnc_conv_t   conv_cfg [0:3],
  output      dnc_pkg::dnc_global_t global_cfg
);

  // ==========================================================================
  // Reset synchroniser
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // Decode helpers
  function automatic logic [15:0] decim_factor(input logic [3:0] code);
    decim_factor = 16'h0;
    if (code != dnc_pkg::DECIM_BYPASS) decim_factor = 16'(17'h1 << code);
  endfunction : decim_factor

  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = access.wr && (a == target);
  endfunction : hit

  // ==========================================================================
  // Register storage
  logic [7:0] complex_reg, source_reg, upd_mode_reg, sel_ctrl_reg;
  logic [7:0] fsel_reg, decim_lo_reg, decim_hi_reg, decim_cfg_reg, zone_reg;
  logic [2:0] zone_live_reg;
  logic [7:0] pin_sel_prev_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      complex_reg   <= dnc_pkg::RESET_BYTE;
      source_reg    <= dnc_pkg::RESET_BYTE;
      upd_mode_reg  <= dnc_pkg::RESET_BYTE;
      sel_ctrl_reg  <= dnc_pkg::RESET_BYTE;
      fsel_reg      <= dnc_pkg::RESET_BYTE;
      decim_lo_reg  <= dnc_pkg::RESET_BYTE;
      decim_hi_reg  <= dnc_pkg::RESET_BYTE;
      decim_cfg_reg <= dnc_pkg::RESET_BYTE;
      zone_reg      <= dnc_pkg::RESET_BYTE;
    end else begin
      if (hit(access.addr, dnc_pkg::ADDR_COMPLEX_CFG))  complex_reg   <= access.wdata;
      if (hit(access.addr, dnc_pkg::ADDR_SOURCE_SEL))   source_reg    <= access.wdata;
      if (hit(access.addr, dnc_pkg::ADDR_OSC_UPD_MODE)) upd_mode_reg  <= access.wdata;
      if (hit(access.addr, dnc_pkg::ADDR_OSC_SEL_CTRL)) sel_ctrl_reg  <= access.wdata;
      if (hit(access.addr, dnc_pkg::ADDR_FREQ_SEL))     fsel_reg      <= access.wdata;
      if (hit(access.addr, dnc_pkg::ADDR_DECIM_LOW))    decim_lo_reg  <= access.wdata;
      if (hit(access.addr, dnc_pkg::ADDR_DECIM_HIGH))   decim_hi_reg  <= access.wdata;
      if (hit(access.addr, dnc_pkg::ADDR_DECIM_COMMON)) decim_cfg_reg <= access.wdata;
      if (hit(access.addr, dnc_pkg::ADDR_ZONE_CFG))     zone_reg      <= access.wdata;
    end
  end

  // ==========================================================================
  // Edge detection on update bits
  logic [3:0] osc_rise;
  logic       common_rise;
  logic       zone_rise;

  for (genvar g = 0; g < dnc_pkg::NUM_CONV; g++) begin : g_osc_edge
    dnc_rise_detect u_edge (
      .clock (clock),
      .rst_n (rst_n),
      .level (upd_mode_reg[dnc_pkg::BIT_OSC_UPD_LO + g]),
      .pulse (osc_rise[g])
    );
  end

  dnc_rise_detect u_common_edge (
    .clock (clock),
    .rst_n (rst_n),
    .level (sel_ctrl_reg[dnc_pkg::BIT_COMMON_UPD]),
    .pulse (common_rise)
  );

  dnc_rise_detect u_zone_edge (
    .clock (clock),
    .rst_n (rst_n),
    .level (zone_reg[dnc_pkg::BIT_ZONE_UPD]),
    .pulse (zone_rise)
  );

  // ==========================================================================
  // Zone copy and pin-select history
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      zone_live_reg    <= dnc_pkg::RESET_ZONE;
      pin_sel_prev_reg <= dnc_pkg::RESET_BYTE;
    end else begin
      if (zone_rise) zone_live_reg <= zone_reg[2:0];
      pin_sel_prev_reg <= pin_freq_select;
    end
  end

  // ==========================================================================
  // Frequency selection source and auto load
  logic       sel_from_reg;
  logic       autoload_off;
  logic [7:0] sel_word;
  logic       pin_changed;
  logic [3:0] load;

  assign sel_from_reg = sel_ctrl_reg[dnc_pkg::BIT_FSEL_SRC];
  assign autoload_off = sel_ctrl_reg[dnc_pkg::BIT_AUTOLOAD_DIS];
  assign sel_word     = sel_from_reg ? fsel_reg : pin_freq_select;
  assign pin_changed  = !sel_from_reg && (pin_freq_select != pin_sel_prev_reg);

  for (genvar g = 0; g < dnc_pkg::NUM_CONV; g++) begin : g_load
    logic pin_auto;
    assign pin_auto = pin_changed && !autoload_off &&
                      (pin_freq_select[2*g+:2] != pin_sel_prev_reg[2*g+:2]);
    assign load[g]  = osc_rise[g] | common_rise | pin_auto;
  end

  // ==========================================================================
  // Frequency word byte port
  logic        freq_hit;
  logic [11:0] freq_off;
  logic [1:0]  freq_osc;
  logic [4:0]  freq_byte;
  logic [7:0]  freq_rd [0:3];

  assign freq_hit  = (access.addr >= dnc_pkg::ADDR_FREQ_BASE) &&
                     (access.addr <= dnc_pkg::ADDR_FREQ_LAST);
  assign freq_off  = 12'(access.addr - dnc_pkg::ADDR_FREQ_BASE);
  assign freq_osc  = freq_off[6:5];
  assign freq_byte = 5'(freq_off[4:0] % 24);

  for (genvar g = 0; g < dnc_pkg::NUM_CONV; g++) begin : g_osc
    dnc_osc_slot u_slot (
      .clock       (clock),
      .rst_n       (rst_n),
      .byte_we     (access.wr && freq_hit && (freq_osc == 2'(g)) && (freq_off[4:0] < 5'h18)),
      .byte_index  (freq_byte),
      .byte_data   (access.wdata),
      .load        (load[g]),
      .select      (sel_word[2*g+:2]),
      .active_freq (conv_cfg[g].active_freq),
      .byte_rdata  (freq_rd[g])
    );
  end

  // ==========================================================================
  // Per-converter source and decimation
  logic unequal;
  logic bypass_all;

  assign unequal    = decim_cfg_reg[dnc_pkg::BIT_UNEQUAL];
  assign bypass_all = sel_ctrl_reg[dnc_pkg::BIT_LOW_LATENCY];

  for (genvar g = 0; g < dnc_pkg::NUM_CONV; g++) begin : g_conv
    logic [1:0] src;
    logic [3:0] own_code;
    logic [3:0] code;
    logic       conn;
    assign src      = source_reg[2*g+:2];
    // Odd converters connect on 01, even ones on 00
    assign conn     = (g % 2 == 1) ? (src == dnc_pkg::SRC_CODE_01)
                                   : (src == dnc_pkg::SRC_CODE_00);
    assign own_code = (g < 2) ? decim_lo_reg[4*(g%2)+:4] : decim_hi_reg[4*(g%2)+:4];
    assign code     = unequal ? own_code : decim_cfg_reg[3:0];
    assign conv_cfg[g].connected    = conn;
    assign conv_cfg[g].decim_code   = code;
    assign conv_cfg[g].decim_factor = decim_factor(code);
    assign conv_cfg[g].bypass       = bypass_all || (code == dnc_pkg::DECIM_BYPASS);
    assign conv_cfg[g].freq_index   = sel_word[2*g+:2];
    assign conv_data[g] = (conn && !bypass_all) ? channel_a : 16'h0;
  end

  // ==========================================================================
  // Global settings
  assign global_cfg.complex_en  = complex_reg[dnc_pkg::BIT_COMPLEX_EN];
  assign global_cfg.neg_image   = complex_reg[dnc_pkg::BIT_COMPLEX_EN] &&
                                  upd_mode_reg[dnc_pkg::BIT_NEG_IMAGE];
  assign global_cfg.coherent    = upd_mode_reg[dnc_pkg::BIT_OSC_MODE];
  assign global_cfg.low_latency = bypass_all;
  assign global_cfg.count       = dnc_pkg::dnc_count_t'(decim_cfg_reg[5:4]);
  assign global_cfg.zone        = zone_live_reg;

  // ==========================================================================
  // Read-back mux, unmapped reads as zero
  logic [7:0] rd_next;

  always_comb begin
    rd_next = 8'h00;
    case (access.addr)
      dnc_pkg::ADDR_COMPLEX_CFG:  rd_next = complex_reg;
      dnc_pkg::ADDR_SOURCE_SEL:   rd_next = source_reg;
      dnc_pkg::ADDR_OSC_UPD_MODE: rd_next = upd_mode_reg;
      dnc_pkg::ADDR_OSC_SEL_CTRL: rd_next = sel_ctrl_reg;
      dnc_pkg::ADDR_FREQ_SEL:     rd_next = fsel_reg;
      dnc_pkg::ADDR_DECIM_LOW:    rd_next = decim_lo_reg;
      dnc_pkg::ADDR_DECIM_HIGH:   rd_next = decim_hi_reg;
      dnc_pkg::ADDR_DECIM_COMMON: rd_next = decim_cfg_reg;
      dnc_pkg::ADDR_ZONE_CFG:     rd_next = zone_reg;
      default: begin
        if (freq_hit && freq_off[4:0] < 5'h18) rd_next = freq_rd[freq_osc];
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd_next;
    end
  end

endmodule : dnc_config_regs

// File: dnc_config_regs_assertions.sv
// Purpose: Port-level checks for the configuration bank
// Assumes: Bound to dnc_config_regs, one clock domain
// Notes:   Keeps a shadow of the written zone update bit
`timescale 1ns/1ps
module dnc_config_regs_assertions (
  input wire logic                 clock,
  input wire logic                 arst_n,
  input wire dnc_pkg::dnc_access_t access,
  input wire logic [7:0]           rdata,
  input wire logic [7:0]           pin_freq_select,
  input wire logic [15:0]          channel_a,
  input wire logic [15:0]          conv_data [0:3],
  input wire dnc_pkg::dnc_conv_t   conv_cfg [0:3],
  input wire dnc_pkg::dnc_global_t global_cfg
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // ====================
  // Helpers
  logic zone_upd_reg;
  wire  zone_wr   = access.wr && access.addr == dnc_pkg::ADDR_ZONE_CFG;
  wire  zone_rise = zone_wr && access.wdata[4] && !zone_upd_reg;

  // Last written level of the zone update bit
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      zone_upd_reg <= 1'b0;
    else if (zone_wr)
      zone_upd_reg <= access.wdata[4];

  // ====================
  // Write sequences
  sequence s_src_wr;
    access.wr && access.addr == dnc_pkg::ADDR_SOURCE_SEL;
  endsequence
  sequence s_dec_wr;
    access.wr && access.addr == dnc_pkg::ADDR_DECIM_COMMON;
  endsequence
  sequence s_zone_rise;
    zone_rise;
  endsequence

  // ====================
  // Properties
  a_src_map: assert property (s_src_wr |=>
    conv_cfg[0].connected == ($past(access.wdata[1:0]) == dnc_pkg::SRC_CODE_00) &&
    conv_cfg[1].connected == ($past(access.wdata[3:2]) == dnc_pkg::SRC_CODE_01))
    else $error("source select mismatch");
  a_data_gate: assert property (conv_data[2] ==
    ((conv_cfg[2].connected && !global_cfg.low_latency) ? channel_a : 16'h0000))
    else $error("converter data gating wrong");
  a_neg_gate: assert property (global_cfg.neg_image |-> global_cfg.complex_en)
    else $error("negative image without complex mode");
  a_factor_pow: assert property (conv_cfg[1].decim_code != dnc_pkg::DECIM_BYPASS |->
    conv_cfg[1].decim_factor == (16'h0001 << conv_cfg[1].decim_code))
    else $error("decimation factor wrong");
  a_bypass_code: assert property (conv_cfg[3].decim_code == dnc_pkg::DECIM_BYPASS |->
    conv_cfg[3].bypass && conv_cfg[3].decim_factor == 16'h0000)
    else $error("bypass code not honoured");
  a_low_lat: assert property (global_cfg.low_latency |->
    conv_cfg[0].bypass && conv_cfg[3].bypass)
    else $error("low latency without bypass");
  a_count_wr: assert property (s_dec_wr |=>
    global_cfg.count == $past(access.wdata[5:4]))
    else $error("converter count not taken");
  a_common_dec: assert property (s_dec_wr ##0 !access.wdata[7] |=>
    conv_cfg[2].decim_code == $past(access.wdata[3:0]))
    else $error("common decimation not applied");
  a_zone_load: assert property (s_zone_rise |->
    ##2 global_cfg.zone == $past(access.wdata[2:0], 2))
    else $error("zone not copied on rising update");
  a_zone_hold: assert property ($changed(global_cfg.zone) |-> $past(zone_rise, 2))
    else $error("zone changed without update");
endmodule : dnc_config_regs_assertions

bind dnc_config_regs dnc_config_regs_assertions u_chk (
  .clock(clock), .arst_n(arst_n), .access(access), .rdata(rdata),
  .pin_freq_select(pin_freq_select), .channel_a(channel_a),
  .conv_data(conv_data), .conv_cfg(conv_cfg), .global_cfg(global_cfg));

// File: tb.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: One write per two cycles, three cycles to settle
// Notes:   Expected frequency words come from a local formula
`timescale 1ns/1ps
module tb;
  logic                 clock;
  logic                 arst_n;
  dnc_pkg::dnc_access_t access;
  logic [7:0]           rdata;
  logic [7:0]           pin_freq_select;
  logic [15:0]          channel_a;
  logic [15:0]          conv_data [0:3];
  dnc_pkg::dnc_conv_t   conv_cfg [0:3];
  dnc_pkg::dnc_global_t global_cfg;
  int                   n_fail = 0;
  int                   n_compared = 0;
  int                   cycles = 0;

  dnc_config_regs uut (.clock(clock), .arst_n(arst_n), .access(access), .rdata(rdata),
    .pin_freq_select(pin_freq_select), .channel_a(channel_a), .conv_data(conv_data),
    .conv_cfg(conv_cfg), .global_cfg(global_cfg));

  // ====================
  // Clock and shared tasks
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    access <= '{1'b1, a, d};
    @(posedge clock);
    access <= '{1'b0, a, d};
  endtask : wr

  // Read data is registered one cycle after the address
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clock);
    access <= '{1'b0, a, 8'h00};
    @(posedge clock);
    #1 chk(48'(rdata), 48'(exp));
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  function automatic logic [47:0] fw(input int g, input int w);
    return {24'h5a5a5a, 8'(g), 8'(w), 8'h3c};
  endfunction : fw

  // Little-endian byte writes of one word
  task automatic put_word(input int g, input int w, input logic [47:0] v);
    for (int b = 0; b < dnc_pkg::FREQ_BYTES; b++)
      wr(dnc_pkg::ADDR_FREQ_BASE + 12'(32 * g + 6 * w + b), v[8*b +: 8]);
  endtask : put_word

  // ====================
  // Scenarios
  task automatic t_reset;
    for (int a = 'h162; a <= 'h16b; a++)
      rd(12'(a), 8'h00);
    chk(48'(global_cfg.count), 48'(dnc_pkg::DNC_MODE_DUAL));
  endtask : t_reset

  task automatic t_rw;
    logic [19:0] t [8] = '{20'h16204, 20'h16344, 20'h16409, 20'h16516,
                           20'h166e4, 20'h16721, 20'h168f0, 20'h1699e};
    for (int i = 0; i < 8; i++)
      wr(t[i][19:8], t[i][7:0]);
    for (int i = 0; i < 8; i++)
      rd(t[i][19:8], t[i][7:0]);
    wr(12'h16a, 8'hff);
    rd(12'h16a, 8'h00);
    chk(48'(conv_cfg[2].bypass), 48'h1);
    for (int i = 0; i < 8; i++)
      wr(t[i][19:8], 8'h00);
  endtask : t_rw

  task automatic t_src;
    for (int c = 0; c < 2; c++) begin
      wr(dnc_pkg::ADDR_SOURCE_SEL, c ? 8'h55 : 8'h00);
      settle;
      for (int g = 0; g < 4; g++)
        chk(48'(conv_data[g]), (g[0] ^ c[0]) ? 48'h0 : 48'(channel_a));
    end
    wr(dnc_pkg::ADDR_OSC_SEL_CTRL, 8'h10);
    settle;
    chk(48'(conv_data[1]), 48'h0);
    wr(dnc_pkg::ADDR_OSC_SEL_CTRL, 8'h00);
    settle;
    chk(48'(conv_data[1]), 48'(channel_a));
  endtask : t_src

  task automatic t_decim;
    logic [3:0] e [4] = '{4'h1, 4'h2, 4'h3, 4'hf};
    for (int c = 0; c < 16; c++) begin
      wr(dnc_pkg::ADDR_DECIM_COMMON, 8'(c));
      settle;
      chk(48'(conv_cfg[c % 4].decim_factor), c ? 48'(1) << c : 48'h0);
      chk(48'(conv_cfg[c % 4].bypass), 48'(c == 0));
    end
    wr(dnc_pkg::ADDR_DECIM_LOW, 8'h21);
    wr(dnc_pkg::ADDR_DECIM_HIGH, 8'hf3);
    wr(dnc_pkg::ADDR_DECIM_COMMON, 8'h8e);
    settle;
    for (int g = 0; g < 4; g++)
      chk(48'(conv_cfg[g].decim_code), 48'(e[g]));
    wr(dnc_pkg::ADDR_DECIM_COMMON, 8'h0e);
    settle;
    for (int g = 0; g < 4; g++)
      chk(48'(conv_cfg[g].decim_code), 48'he);
    for (int c = 0; c < 3; c++) begin
      wr(dnc_pkg::ADDR_DECIM_COMMON, 8'(c << 4));
      settle;
      chk(48'(global_cfg.count), 48'(c));
    end
  endtask : t_decim

  task automatic t_freq;
    for (int g = 0; g < 4; g++)
      for (int w = 0; w < 4; w++)
        put_word(g, w, fw(g, w));
    wr(dnc_pkg::ADDR_OSC_SEL_CTRL, 8'h02);
    wr(dnc_pkg::ADDR_FREQ_SEL, 8'he4);
    settle;
    chk(conv_cfg[3].active_freq, 48'h0);
    wr(dnc_pkg::ADDR_OSC_UPD_MODE, 8'h10);
    settle;
    chk(conv_cfg[0].active_freq, fw(0, 0));
    chk(conv_cfg[1].active_freq, 48'h0);
    wr(dnc_pkg::ADDR_FREQ_BASE, 8'h77);
    wr(dnc_pkg::ADDR_OSC_UPD_MODE, 8'h90);
    settle;
    chk(conv_cfg[3].active_freq, fw(3, 3));
    chk(conv_cfg[0].active_freq, fw(0, 0));
    wr(dnc_pkg::ADDR_OSC_UPD_MODE, 8'hf0);
    settle;
    chk(conv_cfg[1].active_freq, fw(1, 1));
    chk(conv_cfg[2].active_freq, fw(2, 2));
    chk(conv_cfg[0].active_freq, fw(0, 0));
    wr(dnc_pkg::ADDR_OSC_UPD_MODE, 8'h00);
    wr(dnc_pkg::ADDR_OSC_SEL_CTRL, 8'h03);
    settle;
    for (int g = 0; g < 4; g++) begin
      chk(conv_cfg[g].active_freq, g ? fw(g, g) : fw(0, 0) ^ 48'h4b);
      chk(48'(conv_cfg[g].freq_index), 48'(g));
    end
    wr(dnc_pkg::ADDR_OSC_SEL_CTRL, 8'h04);
    wr(12'h246, 8'h99);
    rd(12'h246, 8'h99);
    rd(12'h277, 8'h5a);
    @(posedge clock);
    pin_freq_select <= 8'h1b;
    settle;
    chk(48'(conv_cfg[2].freq_index), 48'h1);
    chk(conv_cfg[2].active_freq, fw(2, 1));
    wr(dnc_pkg::ADDR_OSC_SEL_CTRL, 8'h00);
    @(posedge clock);
    pin_freq_select <= 8'h2b;
    settle;
    @(posedge clock);
    pin_freq_select <= 8'h1b;
    settle;
    chk(conv_cfg[2].active_freq, fw(2, 1) ^ 48'ha5);
  endtask : t_freq

  task automatic t_global;
    logic [7:0] z [3] = '{8'h05, 8'h15, 8'h13};
    logic [2:0] e [3] = '{3'h0, 3'h5, 3'h5};
    for (int i = 0; i < 3; i++) begin
      wr(dnc_pkg::ADDR_ZONE_CFG, z[i]);
      settle;
      chk(48'(global_cfg.zone), 48'(e[i]));
    end
    wr(dnc_pkg::ADDR_OSC_UPD_MODE, 8'h09);
    settle;
    chk(48'(global_cfg.neg_image), 48'h0);
    chk(48'(global_cfg.coherent), 48'h1);
    wr(dnc_pkg::ADDR_COMPLEX_CFG, 8'h04);
    settle;
    chk(48'(global_cfg.complex_en), 48'h1);
    chk(48'(global_cfg.neg_image), 48'h1);
  endtask : t_global

  // ====================
  // Main sequence and hang guard
  initial begin
    arst_n = 1'b0;
    access = '0;
    pin_freq_select = 8'h00;
    channel_a = 16'hbeef;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset;
    t_rw;
    t_src;
    t_decim;
    t_freq;
    t_global;
    wrap_up;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up;
    end
  end
endmodule : tb
